// ### core/cyc_ctrl_end.sv
// controller end: per-constraint down-counters gating mode commands, sleep entry and commands after wake
`timescale 1ns/1ps
`default_nettype none
module cyc_ctrl_end (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst,
    // link
    cyc_link_if.ctrl                    link,
    // user request
    input  wire logic                   req_valid,
    input  wire cyc_timing_pkg::cmd_t   req_cmd,
    input  wire logic                   req_sleep,
    input  wire logic                   req_dll_off,
    input  wire cyc_timing_pkg::burst_t req_burst,
    input  wire logic [7:0]             req_wr_latency,
    output logic                        req_ready,
    output logic                        refresh_due
);
    logic [7:0]  mode_cnt_r, sleep_cnt_r, strobe_cnt_r, rise_cnt_r, lock_cnt_r;
    logic [31:0] ref_cnt_r;
    cyc_timing_pkg::cmd_t cmd_r;
    logic        clk_en_r, drive_r, rise_r, dll_r;
    logic [7:0]  wl_r;
    cyc_timing_pkg::burst_t burst_r;

    // command is blocked until its counter drains
    wire is_mode = (req_cmd == cyc_timing_pkg::CMD_MODE);
    wire mode_ok = (mode_cnt_r == cyc_timing_pkg::ZERO);
    wire wake_ok = (lock_cnt_r == cyc_timing_pkg::ZERO) && clk_en_r;
    assign req_ready = (!is_mode || mode_ok) && wake_ok;
    wire take    = req_valid && req_ready;
    wire sleep_ok = (sleep_cnt_r == cyc_timing_pkg::ZERO);
    wire [7:0] wr_sleep = 8'(req_wr_latency + cyc_timing_pkg::WRITE_TAIL_LONG
                             + cyc_timing_pkg::WRITE_RECOVERY_CYC);

    // down-counters, each loaded with a rounded cycle count
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_cnt_r  <= '0;
            sleep_cnt_r <= '0;
        end else begin
            if (take && (is_mode || req_cmd == cyc_timing_pkg::CMD_READOUT))
                // loaded one short: the take edge itself is the first counted edge
                mode_cnt_r <= is_mode ? cyc_timing_pkg::MODE_SET_SPACING - cyc_timing_pkg::ONE
                                      : cyc_timing_pkg::READOUT_TO_MODE_CYC
                                        - cyc_timing_pkg::ONE;
            else if (mode_cnt_r != cyc_timing_pkg::ZERO)
                mode_cnt_r <= mode_cnt_r - cyc_timing_pkg::ONE;
            if (take && req_cmd == cyc_timing_pkg::CMD_WR)
                sleep_cnt_r <= wr_sleep;
            else if (take && req_cmd == cyc_timing_pkg::CMD_REF)
                sleep_cnt_r <= cyc_timing_pkg::REFRESH_TO_SLEEP_CYC;
            else if (sleep_cnt_r != cyc_timing_pkg::ZERO)
                sleep_cnt_r <= sleep_cnt_r - cyc_timing_pkg::ONE;
        end
    end

    // write leveling strobe waits
    always_ff @(posedge clk) begin
        if (rst) begin
            strobe_cnt_r <= '0;
            rise_cnt_r   <= '0;
            drive_r      <= 1'b0;
            rise_r       <= 1'b0;
        end else if (take && req_cmd == cyc_timing_pkg::CMD_LEVEL) begin
            strobe_cnt_r <= cyc_timing_pkg::LEVEL_STROBE_DRIVE_WAIT;
            rise_cnt_r   <= cyc_timing_pkg::LEVEL_FIRST_STROBE_WAIT;
            drive_r      <= 1'b0;
            rise_r       <= 1'b0;
        end else begin
            if (strobe_cnt_r != cyc_timing_pkg::ZERO)
                strobe_cnt_r <= strobe_cnt_r - cyc_timing_pkg::ONE;
            if (rise_cnt_r != cyc_timing_pkg::ZERO)
                rise_cnt_r <= rise_cnt_r - cyc_timing_pkg::ONE;
            drive_r <= drive_r || (strobe_cnt_r == cyc_timing_pkg::ONE);
            rise_r  <= (rise_cnt_r == cyc_timing_pkg::ONE);
        end
    end

    // clock enable, sleep exit lock wait, refresh interval
    always_ff @(posedge clk) begin
        if (rst) begin
            clk_en_r   <= 1'b1;
            lock_cnt_r <= '0;
            ref_cnt_r  <= '0;
            dll_r      <= 1'b0;
        end else begin
            if (clk_en_r && req_sleep && sleep_ok && !req_valid)
                clk_en_r <= 1'b0;
            else if (!clk_en_r && !req_sleep) begin
                clk_en_r   <= 1'b1;
                lock_cnt_r <= cyc_timing_pkg::SLEEP_EXIT_LOCK_CYC;
            end else if (lock_cnt_r != cyc_timing_pkg::ZERO)
                lock_cnt_r <= lock_cnt_r - cyc_timing_pkg::ONE;
            if (take && req_cmd == cyc_timing_pkg::CMD_REF)
                ref_cnt_r <= '0;
            else if (ref_cnt_r != 32'(cyc_timing_pkg::REFRESH_INTERVAL_CYC))
                ref_cnt_r <= ref_cnt_r + 32'h1;
            dll_r <= req_dll_off;
        end
    end

    // registered command outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            cmd_r   <= cyc_timing_pkg::CMD_NOP;
            wl_r    <= '0;
            burst_r <= cyc_timing_pkg::BURST_FIXED8;
        end else begin
            cmd_r   <= take ? req_cmd : cyc_timing_pkg::CMD_NOP;
            wl_r    <= req_wr_latency;
            burst_r <= req_burst;
        end
    end

    assign refresh_due       = (ref_cnt_r == 32'(cyc_timing_pkg::REFRESH_INTERVAL_CYC));
    assign link.cmd          = cmd_r;
    assign link.cmd_chop     = (burst_r == cyc_timing_pkg::BURST_CHOP4);
    assign link.wr_latency   = wl_r;
    assign link.wr_recovery  = cyc_timing_pkg::WRITE_RECOVERY_CYC;
    assign link.burst_mode   = burst_r;
    assign link.clk_en       = clk_en_r;
    assign link.strobe_drive = drive_r;
    assign link.strobe_rise  = rise_r;
    assign link.dll_off      = dll_r;
endmodule
`default_nettype wire

// ### core/cyc_link_if.sv
// command link between memory controller and memory device
`timescale 1ns/1ps
`default_nettype none
interface cyc_link_if (
    input wire logic clk
);
    cyc_timing_pkg::cmd_t   cmd;
    logic                   cmd_chop;
    logic [7:0]             wr_latency;
    logic [7:0]             wr_recovery;
    cyc_timing_pkg::burst_t burst_mode;
    logic                   clk_en;
    logic                   strobe_drive;
    logic                   strobe_rise;
    logic                   dll_off;
    logic                   wr_start;
    logic                   cal_done;
    logic                   busy;
    logic                   asleep;
    modport ctrl (
        input  clk, wr_start, cal_done, busy, asleep,
        output cmd, cmd_chop, wr_latency, wr_recovery, burst_mode, clk_en,
               strobe_drive, strobe_rise, dll_off
    );
    modport dev (
        input  clk, cmd, cmd_chop, wr_latency, wr_recovery, burst_mode, clk_en,
               strobe_drive, strobe_rise, dll_off,
        output wr_start, cal_done, busy, asleep
    );
endinterface
`default_nettype wire

// ### core/cyc_mem_end.sv
// memory device end: internal write start, busy tracking, sleep, calibration
`timescale 1ns/1ps
`default_nettype none
module cyc_mem_end (
    // clock and reset
    input  wire logic      clk,
    input  wire logic      rst,
    // link
    cyc_link_if.dev        link,
    // user side
    output logic           auto_pre_pulse,
    output logic [7:0]     recovery_seen
);
    logic [7:0] wr_cnt_r, wr_cnt_nxt;
    logic [7:0] busy_cnt_r;
    logic [7:0] cal_cnt_r;
    logic [7:0] ap_cnt_r;
    logic [7:0] rec_r;
    logic       wr_start_r, cal_done_r, asleep_r;
    cyc_timing_pkg::dev_state_t st_r;

    // tail after write latency depends on burst mode
    wire        fixed_chop = (link.burst_mode == cyc_timing_pkg::BURST_CHOP4);
    wire [7:0]  wr_tail    = fixed_chop ? cyc_timing_pkg::WRITE_TAIL_CHOP
                                        : cyc_timing_pkg::WRITE_TAIL_LONG;
    wire        is_wr      = (link.cmd == cyc_timing_pkg::CMD_WR);
    wire        is_ref     = (link.cmd == cyc_timing_pkg::CMD_REF);
    wire        is_row     = (link.cmd == cyc_timing_pkg::CMD_ACT)
                           || (link.cmd == cyc_timing_pkg::CMD_PRE);
    wire        is_cal     = (link.cmd == cyc_timing_pkg::CMD_CAL);
    wire        busy_now   = (busy_cnt_r != cyc_timing_pkg::ZERO) || (ap_cnt_r != cyc_timing_pkg::ZERO);

    // write counter counts real clock edges
    always_comb begin
        wr_cnt_nxt = wr_cnt_r;
        if (is_wr)
            wr_cnt_nxt = 8'(link.wr_latency + wr_tail - cyc_timing_pkg::ONE);
        else if (wr_cnt_r != cyc_timing_pkg::ZERO)
            wr_cnt_nxt = wr_cnt_r - cyc_timing_pkg::ONE;
    end

    // internal write start, auto-precharge from mode register recovery
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_cnt_r   <= '0;
            wr_start_r <= 1'b0;
            ap_cnt_r   <= '0;
            rec_r      <= '0;
        end else begin
            wr_cnt_r   <= wr_cnt_nxt;
            wr_start_r <= (wr_cnt_r == cyc_timing_pkg::ONE);
            if (link.cmd == cyc_timing_pkg::CMD_MODE)
                rec_r <= link.wr_recovery;
            if (wr_start_r)
                ap_cnt_r <= rec_r;
            else if (ap_cnt_r != cyc_timing_pkg::ZERO)
                ap_cnt_r <= ap_cnt_r - cyc_timing_pkg::ONE;
        end
    end

    // busy operations finish even after clock enable drops
    always_ff @(posedge clk) begin
        if (rst) begin
            busy_cnt_r <= '0;
            st_r       <= cyc_timing_pkg::DEV_IDLE;
            asleep_r   <= 1'b0;
        end else begin
            if (is_ref)
                busy_cnt_r <= cyc_timing_pkg::REFRESH_BUSY_CYCLES;
            else if (is_row && busy_cnt_r < cyc_timing_pkg::ROW_BUSY_CYCLES)
                busy_cnt_r <= cyc_timing_pkg::ROW_BUSY_CYCLES;
            else if (busy_cnt_r != cyc_timing_pkg::ZERO)
                busy_cnt_r <= busy_cnt_r - cyc_timing_pkg::ONE;
            case (st_r)
                cyc_timing_pkg::DEV_IDLE: begin
                    if (!link.clk_en)
                        st_r <= busy_now ? cyc_timing_pkg::DEV_BUSY : cyc_timing_pkg::DEV_SLEEP;
                end
                cyc_timing_pkg::DEV_BUSY: begin
                    if (link.clk_en)
                        st_r <= cyc_timing_pkg::DEV_IDLE;
                    else if (!busy_now)
                        st_r <= cyc_timing_pkg::DEV_SLEEP;
                end
                cyc_timing_pkg::DEV_SLEEP: begin
                    if (link.clk_en)
                        st_r <= cyc_timing_pkg::DEV_IDLE;
                end
                default: st_r <= cyc_timing_pkg::DEV_IDLE;
            endcase
            asleep_r <= (st_r == cyc_timing_pkg::DEV_SLEEP) && !link.clk_en;
        end
    end

    // short calibration completes in its fixed window
    always_ff @(posedge clk) begin
        if (rst) begin
            cal_cnt_r  <= '0;
            cal_done_r <= 1'b0;
        end else begin
            cal_done_r <= (cal_cnt_r == cyc_timing_pkg::ONE);
            if (is_cal)
                cal_cnt_r <= cyc_timing_pkg::CAL_SHORT_CYCLES - cyc_timing_pkg::ONE;
            else if (cal_cnt_r != cyc_timing_pkg::ZERO)
                cal_cnt_r <= cal_cnt_r - cyc_timing_pkg::ONE;
        end
    end

    assign link.wr_start  = wr_start_r;
    assign link.cal_done  = cal_done_r;
    assign link.busy      = busy_now;
    assign link.asleep    = asleep_r && !link.clk_en; // drops at once on wake
    assign auto_pre_pulse = (ap_cnt_r == cyc_timing_pkg::ONE);
    assign recovery_seen  = rec_r;
endmodule
`default_nettype wire

// ### core/cyc_timing_pkg.sv
// constants and types shared by both ends of the command timing link
package cyc_timing_pkg;
    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned CW            = 8;
    localparam logic [7:0] LEVEL_FIRST_STROBE_WAIT = 8'h28;
    localparam logic [7:0] LEVEL_STROBE_DRIVE_WAIT = 8'h19;
    localparam logic [7:0] MODE_SET_SPACING        = 8'h04;
    localparam logic [7:0] CAL_SHORT_CYCLES        = 8'h40;
    localparam logic [7:0] WRITE_TAIL_LONG         = 8'h04;
    localparam logic [7:0] WRITE_TAIL_CHOP         = 8'h02;
    localparam logic [7:0] REFRESH_BUSY_CYCLES     = 8'h20;
    localparam logic [7:0] ROW_BUSY_CYCLES         = 8'h03;
    localparam logic [7:0] ONE                     = 8'h01;
    localparam logic [7:0] ZERO                    = 8'h00;
    localparam int unsigned WRITE_RECOVERY_PS      = 15000;
    localparam int unsigned REFRESH_TO_SLEEP_PS    = 5000;
    localparam int unsigned SLEEP_EXIT_LOCK_PS     = 24000;
    localparam int unsigned READOUT_TO_MODE_PS     = 15000;
    localparam int unsigned REFRESH_INTERVAL_PS    = 7800000;
    // whole cycles for a least time, never under one
    function automatic logic [7:0] ns_to_cycles(input int unsigned ps);
        int unsigned c;
        c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        if (c < 1) c = 1;
        return c[7:0];
    endfunction
    localparam logic [7:0] WRITE_RECOVERY_CYC   = ns_to_cycles(WRITE_RECOVERY_PS);
    localparam logic [7:0] REFRESH_TO_SLEEP_CYC = ns_to_cycles(REFRESH_TO_SLEEP_PS);
    localparam logic [7:0] SLEEP_EXIT_LOCK_CYC  = ns_to_cycles(SLEEP_EXIT_LOCK_PS);
    localparam logic [7:0] READOUT_TO_MODE_CYC  = ns_to_cycles(READOUT_TO_MODE_PS);
    localparam int unsigned REFRESH_INTERVAL_CYC = REFRESH_INTERVAL_PS / CLK_PERIOD_PS;
    typedef enum logic [3:0] {
        CMD_NOP = 4'h0, CMD_MODE = 4'h1, CMD_ACT = 4'h2, CMD_PRE = 4'h3,
        CMD_REF = 4'h4, CMD_WR = 4'h5, CMD_RD = 4'h6, CMD_CAL = 4'h7,
        CMD_LEVEL = 4'h8, CMD_READOUT = 4'h9
    } cmd_t;
    typedef enum logic [1:0] {
        BURST_FIXED8 = 2'h0, BURST_FLY = 2'h1, BURST_CHOP4 = 2'h2
    } burst_t;
    typedef enum logic [1:0] {
        DEV_IDLE = 2'h0, DEV_BUSY = 2'h1, DEV_SLEEP = 2'h3
    } dev_state_t;
endpackage

// ### tb/cyc_link_props.sv
// concurrent checks on the command link between the two ends
`timescale 1ns/1ps
`default_nettype none
module cyc_link_props (
    // clock and reset
    input wire logic                   clk,
    input wire logic                   rst,
    // link signals
    input wire cyc_timing_pkg::cmd_t   cmd,
    input wire cyc_timing_pkg::burst_t burst_mode,
    input wire logic [7:0]             wr_latency,
    input wire logic                   clk_en,
    input wire logic                   strobe_drive,
    input wire logic                   strobe_rise,
    input wire logic                   wr_start,
    input wire logic                   cal_done,
    input wire logic                   busy,
    input wire logic                   asleep
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [8:0] wcnt_r, wcnt_nxt, scnt_r, scnt_nxt, lcnt_r;
    wire        is_wr = (cmd == cyc_timing_pkg::CMD_WR);
    wire        chop  = (burst_mode == cyc_timing_pkg::BURST_CHOP4);
    // countdowns to write start and to the earliest sleep entry
    assign wcnt_nxt = is_wr ? {1'b0, wr_latency} + (chop ? 9'h002 : 9'h004)
                    : (wcnt_r != 9'h000) ? wcnt_r - 9'h001 : wcnt_r;
    assign scnt_nxt = is_wr ? {1'b0, wr_latency} + 9'h007
                    : (cmd == cyc_timing_pkg::CMD_REF) ? 9'h001
                    : (scnt_r != 9'h000) ? scnt_r - 9'h001 : scnt_r;
    // cycles since leveling was programmed, saturating
    always_ff @(posedge clk) begin
        if (rst) begin
            wcnt_r <= 9'h000;
            scnt_r <= 9'h000;
            lcnt_r <= 9'h1ff;
        end else begin
            wcnt_r <= wcnt_nxt;
            scnt_r <= scnt_nxt;
            lcnt_r <= (cmd == cyc_timing_pkg::CMD_LEVEL) ? 9'h001
                    : (lcnt_r != 9'h1ff) ? lcnt_r + 9'h001 : lcnt_r;
        end
    end
    chk_mode_spacing: assert property (cmd == cyc_timing_pkg::CMD_MODE |=>
        (cmd != cyc_timing_pkg::CMD_MODE)[*3]) else $error("mode set too soon");
    chk_readout_mode: assert property (cmd == cyc_timing_pkg::CMD_READOUT |=>
        (cmd != cyc_timing_pkg::CMD_MODE)[*2]) else $error("mode set too soon after readout");
    chk_write_due: assert property (wcnt_r == 9'h001 |-> wr_start)
        else $error("internal write start missing");
    chk_write_early: assert property (wr_start |-> wcnt_r == 9'h001)
        else $error("internal write start at wrong cycle");
    chk_cal_done: assert property (cmd == cyc_timing_pkg::CMD_CAL |-> ##64 cal_done)
        else $error("calibration not done in 64 cycles");
    chk_strobe_drive: assert property ($rose(strobe_drive) |-> lcnt_r >= 9'h019 &&
        lcnt_r <= 9'h01a) else $error("strobe driven at wrong time");
    chk_strobe_rise: assert property (strobe_rise |-> lcnt_r >= 9'h028 &&
        lcnt_r <= 9'h029 && strobe_drive) else $error("strobe edge at wrong time");
    chk_sleep_space: assert property ($fell(clk_en) |-> scnt_r <= 9'h001)
        else $error("sleep entered too soon");
    chk_asleep_idle: assert property (asleep |-> !busy && !clk_en)
        else $error("asleep while busy");
    chk_wake_lock: assert property ($rose(clk_en) |->
        (cmd == cyc_timing_pkg::CMD_NOP)[*4]) else $error("command before lock wait");
    cover property (wr_start && chop);
    cover property (cal_done);
    cover property (asleep);
    cover property (strobe_rise);
endmodule
`default_nettype wire

// ### tb/tb_ddr3_cycle_timing_rules.sv
// self-checking bench joining controller end and memory end
`timescale 1ns/1ps
`default_nettype none
module tb_ddr3_cycle_timing_rules;
    logic clk = 1'b0, rst = 1'b1, req_valid = 1'b0, req_sleep = 1'b0, req_dll_off = 1'b0;
    cyc_timing_pkg::cmd_t   req_cmd = cyc_timing_pkg::CMD_NOP;
    cyc_timing_pkg::burst_t req_burst = cyc_timing_pkg::BURST_FIXED8;
    logic [7:0] req_wr_latency = 8'h05, recovery_seen;
    logic       req_ready, refresh_due, auto_pre_pulse;
    int         miscompares = 0, checked = 0, cyc = 0, tcnt = 0;
    int         last_mode = -100, last_ro = -100, lvl_t = -1000, wq[$], cq[$], aq[$];
    int         last_ref = 1;
    localparam int REF_GAP = cyc_timing_pkg::REFRESH_INTERVAL_PS / cyc_timing_pkg::CLK_PERIOD_PS;
    localparam int RO_GAP = (cyc_timing_pkg::READOUT_TO_MODE_PS
        + cyc_timing_pkg::CLK_PERIOD_PS - 1) / cyc_timing_pkg::CLK_PERIOD_PS;
    localparam int REC = (cyc_timing_pkg::WRITE_RECOVERY_PS
        + cyc_timing_pkg::CLK_PERIOD_PS - 1) / cyc_timing_pkg::CLK_PERIOD_PS;
    always #2.5 clk = ~clk;
    cyc_link_if lk (.clk(clk));
    cyc_ctrl_end i_cyc_ctrl_end (.clk(clk), .rst(rst), .link(lk), .req_valid(req_valid),
        .req_cmd(req_cmd), .req_sleep(req_sleep), .req_dll_off(req_dll_off),
        .req_burst(req_burst), .req_wr_latency(req_wr_latency), .req_ready(req_ready),
        .refresh_due(refresh_due));
    cyc_mem_end i_cyc_mem_end (.clk(clk), .rst(rst), .link(lk),
        .auto_pre_pulse(auto_pre_pulse), .recovery_seen(recovery_seen));
    cyc_link_props i_cyc_link_props (.clk(clk), .rst(rst), .cmd(lk.cmd),
        .burst_mode(lk.burst_mode), .wr_latency(lk.wr_latency), .clk_en(lk.clk_en),
        .strobe_drive(lk.strobe_drive), .strobe_rise(lk.strobe_rise), .wr_start(lk.wr_start),
        .cal_done(lk.cal_done), .busy(lk.busy), .asleep(lk.asleep));
    task automatic final_report;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, got);
        end
    endtask
    // one request, held until the controller takes it
    task automatic issue(input cyc_timing_pkg::cmd_t c);
        int n;
        n = 0;
        @(posedge clk);
        #1 req_valid = 1'b1;
        req_cmd = c;
        @(posedge clk);
        while (req_ready !== 1'b1 && n < 300) begin
            @(posedge clk);
            n++;
        end
        if (n >= 300) miscompares++;
        #1 req_valid = 1'b0;
        req_cmd = cyc_timing_pkg::CMD_NOP;
    endtask
    // command, then sleep request until the device sleeps
    task automatic doze(input cyc_timing_pkg::cmd_t c);
        int n;
        n = 0;
        issue(c);
        req_sleep = 1'b1;
        while (lk.asleep !== 1'b1 && n < 200) begin
            @(posedge clk);
            #1 n++;
        end
        if (n >= 200) miscompares++;
        cmp("clk_en", 32'h0, {31'h0, lk.clk_en});
        @(posedge clk);
        #1 req_sleep = 1'b0;
    endtask
    // reference model: pulse times and command gaps from commands on the link
    always @(posedge clk) begin
        tcnt++;
        if (tcnt == 5000) begin
            miscompares++;
            final_report;
        end
        if (!rst) begin
            cyc++;
            cmp("wr_start", {31'h0, wq.size() > 0 && wq[0] == cyc}, {31'h0, lk.wr_start});
            if (wq.size() > 0 && wq[0] == cyc) void'(wq.pop_front());
            cmp("cal_done", {31'h0, cq.size() > 0 && cq[0] == cyc}, {31'h0, lk.cal_done});
            if (cq.size() > 0 && cq[0] == cyc) void'(cq.pop_front());
            cmp("auto_pre_pulse", {31'h0, aq.size() > 0 && aq[0] == cyc}, {31'h0, auto_pre_pulse});
            if (aq.size() > 0 && aq[0] == cyc) void'(aq.pop_front());
            if (lk.wr_start) aq.push_back(cyc + REC);
            if (lk.cmd == cyc_timing_pkg::CMD_REF) last_ref = cyc;
            cmp("refresh_due", {31'h0, cyc - last_ref >= REF_GAP}, {31'h0, refresh_due});
            if (cyc - lvl_t < 25) cmp("strobe_drive", 32'h0, {31'h0, lk.strobe_drive});
            if (cyc - lvl_t > 27 && cyc - lvl_t < 60) cmp("strobe_drive", 32'h1, {31'h0, lk.strobe_drive});
            if (cyc - lvl_t < 60) cmp("strobe_rise", {31'h0, cyc - lvl_t == 40}, {31'h0, lk.strobe_rise});
            if (lk.cmd == cyc_timing_pkg::CMD_LEVEL) lvl_t = cyc;
            if (lk.cmd == cyc_timing_pkg::CMD_WR)
                wq.push_back(cyc + req_wr_latency + (req_burst == cyc_timing_pkg::BURST_CHOP4 ? 2 : 4));
            if (lk.cmd == cyc_timing_pkg::CMD_CAL) cq.push_back(cyc + 64);
            if (lk.cmd == cyc_timing_pkg::CMD_MODE) begin
                if (last_ro < last_mode && cyc - last_mode < 10) cmp("mode gap", 32'd4, cyc - last_mode);
                if (last_ro > last_mode && cyc - last_ro < 10) cmp("readout gap", RO_GAP, cyc - last_ro);
                last_mode = cyc;
            end
            if (lk.cmd == cyc_timing_pkg::CMD_READOUT) last_ro = cyc;
        end
    end
    // main sequence
    initial begin
        void'($urandom(32'h07fd285d));
        repeat (5) @(posedge clk);
        #1 rst = 1'b0;
        cmp("cmd", 32'h0, {28'h0, lk.cmd});
        cmp("clk_en", 32'h1, {31'h0, lk.clk_en});
        issue(cyc_timing_pkg::CMD_LEVEL);
        repeat (60) @(posedge clk);
        issue(cyc_timing_pkg::CMD_MODE);
        issue(cyc_timing_pkg::CMD_MODE);
        issue(cyc_timing_pkg::CMD_READOUT);
        issue(cyc_timing_pkg::CMD_MODE);
        repeat (3) @(posedge clk);
        cmp("recovery_seen", REC, {24'h0, recovery_seen});
        for (int i = 0; i < 12; i++) begin
            #1 req_burst = cyc_timing_pkg::burst_t'(i % 3);
            req_wr_latency = 8'($urandom_range(1, 12));
            issue(cyc_timing_pkg::CMD_WR);
            repeat (24) @(posedge clk);
        end
        issue(cyc_timing_pkg::CMD_CAL);
        repeat (70) @(posedge clk);
        doze(cyc_timing_pkg::CMD_ACT);
        doze(cyc_timing_pkg::CMD_WR);
        issue(cyc_timing_pkg::CMD_MODE);
        req_dll_off = 1'b1;
        repeat (1600) @(posedge clk);
        doze(cyc_timing_pkg::CMD_REF);
        issue(cyc_timing_pkg::CMD_REF);
        repeat (40) @(posedge clk);
        final_report;
    end
endmodule
`default_nettype wire
